// [core/nand_host_map.svh]
// command codes, address values and timing counts for the nand read host
// assumes a 200 MHz system clock
`ifndef NAND_HOST_MAP_SVH
`define NAND_HOST_MAP_SVH
`define CMD_PLANE_SEL 8'h06
`define CMD_COL_CHG 8'h05
`define CMD_CONFIRM 8'he0
`define CMD_IDENT 8'h90
`define CMD_PARAM 8'hec
`define ADDR_ID_DEV 8'h00
`define ADDR_ID_ONFI 8'h20
`define ID_DEV_BYTES 4'h5
`define ID_ONFI_BYTES 4'h4
`define PARAM_COPY_LEN 16'h0100
`define ADDR_CYC_PLANE 3'h5
`define ADDR_CYC_COL 3'h2
`define ADDR_CYC_ONE 3'h1
`define ADDR_PARAM 8'h00
`define TIME_WHR_NS 60
`define TIME_CYCLE_NS 25
`define CLK_PERIOD_NS 5
`define WHR_CYCLES 8'((`TIME_WHR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HALF_CYCLES 8'((`TIME_CYCLE_NS + 2 * `CLK_PERIOD_NS - 1) / (2 * `CLK_PERIOD_NS))
`endif

// [core/nand_host_pkg.sv]
// types shared by the nand read host
// assumes nand_host_map.svh supplies the numbers
`default_nettype none
package nand_host_pkg;
  typedef enum logic [1:0] {OP_PLANE, OP_COLUMN, OP_IDENT, OP_PARAM} op_e;
  typedef struct packed {
    op_e op;
    logic [15:0] column;
    logic [23:0] row;
    logic [7:0] id_addr;
    logic [15:0] count;
  } request_s;
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [7:0] dq_out;
    logic dq_oe;
  } pins_s;
endpackage : nand_host_pkg
`default_nettype wire

// [core/nand_read_host.sv]
// host sequencer for nand plane select, id and parameter page reads
// assumes a single clock, pins synchronous, device on a single chip enable
`timescale 1ns/100ps
`default_nettype none
`include "nand_host_map.svh"

// Behaviour
// - plane select: 06h, 2 col, 3 row, E0h
// - plane select issued only while ready
// - wait turnaround delay before first read; parameter page reads start as soon as ready returns
// - reissue plane select for other plane
// - column-only change uses 05h/E0h
// - id: 90h, 00h, five read strobes; host strobes req.count times instead
// - column change honoured during parameter page
// - 05h, two column cycles, E0h
module nand_read_host (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic REQ_VALID,
  input wire nand_host_pkg::request_s REQ,
  output logic REQ_READY,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic DONE,
  output nand_host_pkg::pins_s PINS,
  input wire logic [7:0] DQ_IN,
  input wire logic READY
);
  import nand_host_pkg::*;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_CMD, S_ADDR, S_CONF, S_BUSY, S_WAIT, S_READ
  } state_e;

  state_e state, next_state;
  request_s req, next_req;
  pins_s pins, next_pins;
  logic [2:0] addr_idx, next_addr_idx;
  logic [2:0] addr_cnt, next_addr_cnt;
  logic [7:0] timer, next_timer;
  logic phase, next_phase;
  logic [15:0] left, next_left;
  logic [7:0] rd_data, next_rd_data;
  logic rd_valid, next_rd_valid;
  logic done, next_done;
  logic saw_busy, next_saw_busy;
  logic req_ready, next_req_ready;
  logic [7:0] cmd_byte;
  logic [7:0] addr_byte;

  always_comb begin
    unique case (req.op)
      OP_PLANE: cmd_byte = `CMD_PLANE_SEL;
      OP_COLUMN: cmd_byte = `CMD_COL_CHG;
      OP_IDENT: cmd_byte = `CMD_IDENT;
      OP_PARAM: cmd_byte = `CMD_PARAM;
    endcase
  end

  // address cycles: column low, column high, then row low to high
  always_comb begin
    unique case (addr_idx)
      3'h0: addr_byte = (req.op == OP_IDENT) ? req.id_addr : req.column[7:0];
      3'h1: addr_byte = req.column[15:8];
      3'h2: addr_byte = req.row[7:0];
      3'h3: addr_byte = req.row[15:8];
      default: addr_byte = req.row[23:16];
    endcase
  end

  always_comb begin
    next_state = state;
    next_req = req;
    next_pins = pins;
    next_addr_idx = addr_idx;
    next_addr_cnt = addr_cnt;
    next_timer = timer;
    next_phase = phase;
    next_left = left;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    next_done = 1'b0;
    next_saw_busy = saw_busy;
    if (timer != 8'h00) begin
      next_timer = timer - 8'h01;
    end else begin
      unique case (state)
        S_IDLE: begin
          next_pins.ce_n = 1'b1;
          // plane select waits for ready; no command goes to a busy die
          if (REQ_VALID && READY) begin
            next_req = REQ;
            next_pins.ce_n = 1'b0;
            next_state = S_CMD;
            next_phase = 1'b0;
          end
        end
        S_CMD: begin
          if (!phase) begin
            next_pins.cle = 1'b1;
            next_pins.we_n = 1'b0;
            next_pins.dq_out = cmd_byte;
            next_pins.dq_oe = 1'b1;
            next_phase = 1'b1;
          end else begin
            next_pins.we_n = 1'b1;
            next_phase = 1'b0;
            next_addr_idx = 3'h0;
            unique case (req.op)
              OP_PLANE: next_addr_cnt = `ADDR_CYC_PLANE;
              OP_COLUMN: next_addr_cnt = `ADDR_CYC_COL;
              OP_IDENT: next_addr_cnt = `ADDR_CYC_ONE;
              OP_PARAM: next_addr_cnt = `ADDR_CYC_ONE;
            endcase
            next_state = S_ADDR;
          end
          next_timer = `HALF_CYCLES;
        end
        S_ADDR: begin
          next_pins.cle = 1'b0;
          if (!phase) begin
            next_pins.ale = 1'b1;
            next_pins.we_n = 1'b0;
            next_pins.dq_out = (req.op == OP_PARAM) ? `ADDR_PARAM : addr_byte;
            next_phase = 1'b1;
          end else begin
            next_pins.we_n = 1'b1;
            next_phase = 1'b0;
            next_addr_idx = addr_idx + 3'h1;
            if (addr_idx + 3'h1 == addr_cnt) begin
              next_state = (req.op == OP_PLANE || req.op == OP_COLUMN) ?
                S_CONF : S_BUSY;
            end
          end
          next_timer = `HALF_CYCLES;
          next_saw_busy = 1'b0;
        end
        S_CONF: begin
          next_pins.ale = 1'b0;
          if (!phase) begin
            next_pins.cle = 1'b1;
            next_pins.we_n = 1'b0;
            next_pins.dq_out = `CMD_CONFIRM;
            next_phase = 1'b1;
            next_timer = `HALF_CYCLES;
          end else begin
            next_pins.we_n = 1'b1;
            next_phase = 1'b0;
            next_state = S_WAIT;
            next_timer = `WHR_CYCLES;
          end
        end
        S_BUSY: begin
          next_pins.ale = 1'b0;
          next_pins.cle = 1'b0;
          next_pins.dq_oe = 1'b0;
          // parameter load: wait for busy then ready before reading
          if (req.op != OP_PARAM) begin
            next_state = S_WAIT;
            next_timer = `WHR_CYCLES;
          end else if (!READY) begin
            next_saw_busy = 1'b1;
          end else if (saw_busy) begin
            // through the wait state so the byte count gets loaded
            next_state = S_WAIT;
          end
        end
        S_WAIT: begin
          next_pins.cle = 1'b0;
          next_pins.dq_oe = 1'b0;
          next_left = req.count;
          next_state = (req.count == 16'h0000) ? S_IDLE : S_READ;
          next_done = (req.count == 16'h0000);
        end
        S_READ: begin
          next_pins.dq_oe = 1'b0;
          // one byte per strobe; device steps its column itself
          if (!phase) begin
            next_pins.re_n = 1'b0;
            next_phase = 1'b1;
          end else begin
            next_pins.re_n = 1'b1;
            next_phase = 1'b0;
            next_rd_data = DQ_IN;
            next_rd_valid = 1'b1;
            next_left = left - 16'h0001;
            if (left == 16'h0001) begin
              next_state = S_IDLE;
              next_done = 1'b1;
            end
          end
          next_timer = `HALF_CYCLES;
        end
        default: next_state = S_IDLE;
      endcase
    end
    next_req_ready = (next_state == S_IDLE) && (next_timer == 8'h00);
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      state <= S_IDLE;
      req <= '0;
      pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                dq_out: 8'h00, dq_oe: 1'b0};
      addr_idx <= 3'h0;
      addr_cnt <= 3'h0;
      timer <= 8'h00;
      phase <= 1'b0;
      left <= 16'h0000;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      done <= 1'b0;
      saw_busy <= 1'b0;
      req_ready <= 1'b1;
    end else begin
      state <= next_state;
      req <= next_req;
      pins <= next_pins;
      addr_idx <= next_addr_idx;
      addr_cnt <= next_addr_cnt;
      timer <= next_timer;
      phase <= next_phase;
      left <= next_left;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      done <= next_done;
      saw_busy <= next_saw_busy;
      req_ready <= next_req_ready;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  always_comb begin
    PINS = pins;
    RD_DATA = rd_data;
    RD_VALID = rd_valid;
    DONE = done;
    REQ_READY = req_ready;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_start_ready: assert property (@(posedge CLOCK) disable iff (!NRST)
    (state == S_IDLE && timer == 8'h00 && REQ_VALID && READY)
    |=> state == S_CMD)
    else $error("request accepted path broken");
  chk_whr_gap: assert property (@(posedge CLOCK) disable iff (!NRST)
    (state == S_CONF && next_state == S_WAIT) |=> pins.re_n [*8])
    else $error("read strobe too soon after confirm");
  chk_confirm_byte: assert property (@(posedge CLOCK) disable iff (!NRST)
    (state == S_CONF && !phase && timer == 8'h00)
    |=> pins.cle && pins.dq_out == `CMD_CONFIRM)
    else $error("confirm byte wrong");
  chk_param_busy: assert property (@(posedge CLOCK) disable iff (!NRST)
    (state == S_BUSY && req.op == OP_PARAM && !saw_busy)
    |=> state == S_BUSY)
    else $error("parameter read before busy seen");
  chk_read_capture: assert property (@(posedge CLOCK) disable iff (!NRST)
    (state == S_READ && phase && timer == 8'h00)
    |=> rd_valid && rd_data == $past(DQ_IN))
    else $error("read byte not captured");
  chk_no_write_read: assert property (@(posedge CLOCK) disable iff (!NRST)
    !pins.re_n |-> !pins.dq_oe && pins.we_n)
    else $error("bus contention on read");
endmodule : nand_read_host
`default_nettype wire

// [sim/nand_dev_model.sv]
// nand device model: id codes, parameter page, two planes
// assumes host pins are registered on the same clock as the model
`timescale 1ns/100ps
`default_nettype none
module nand_dev_model #(
  parameter logic [7:0] MFR_CODE = 8'h3c, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5a, // arbitrary value
  parameter int WHR = 12,
  parameter int BUSY_CYC = 20
) (
  input wire logic clock,
  input wire logic nrst,
  input wire nand_host_pkg::pins_s pins,
  input wire logic hold_busy,
  output logic [7:0] dq_in,
  output logic ready,
  output logic err
);
  import nand_host_pkg::*;
  localparam logic [7:0] IDV [5] = '{MFR_CODE, DEV_CODE, 8'h90, 8'h95, 8'h04};
  localparam logic [7:0] ONF [4] = '{8'h4f, 8'h4e, 8'h46, 8'h49};
  logic we_q, re_q;
  logic [7:0] cmd, dq;
  logic [7:0] ab [3];
  logic [2:0] na;
  logic [15:0] ptr;
  int mode, busy, since;
  // ----------------------------------------
  // array contents
  // ----------------------------------------
  function automatic logic [7:0] page(logic [7:0] c);
    case (c)
      0, 1, 2, 3: return ONF[c[1:0]];
      133: return 8'hbc;
      134: return 8'h02;
      135: return 8'h10;
      136: return 8'h27;
      137: return 8'h19;
      164: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction : page
  function automatic logic [7:0] pick(int m, logic [15:0] c);
    logic [15:0] k;
    k = 16'h4f4e;
    for (int i = 0; i < 254; i++) begin
      k = k ^ {page(8'(i)), 8'h00};
      repeat (8) k = k[15] ? {k[14:0], 1'b0} ^ 16'h8005 : {k[14:0], 1'b0};
    end
    case (m)
      0: return c[7:0];
      1: return c[7:0] ^ 8'ha5;
      2: return IDV[c % 5];
      3: return ONF[c % 4];
      default: case (c[7:0])
        8'hfe: return k[7:0];
        8'hff: return k[15:8];
        default: return page(c[7:0]);
      endcase
    endcase
  endfunction : pick
  // released bus shows the inverse, so a stale capture cannot match
  assign dq_in = (pins.ce_n || pins.dq_oe) ? ~dq : dq;
  assign ready = busy == 0 && !hold_busy;
  always @(posedge clock) begin
    we_q <= pins.we_n;
    re_q <= pins.re_n;
    since <= since + 1;
    if (busy > 0) busy <= busy - 1;
    if (!nrst) begin
      err <= 0;
      busy <= 0;
      mode <= 0;
      ptr <= 0;
      dq <= 0;
    end else begin
      if (!we_q && pins.we_n && !pins.ce_n) begin
        since <= 0;
        if (pins.cle) begin
          if (pins.dq_out == 8'h06 && !ready) err <= 1;
          if (pins.dq_out == 8'he0) begin
            ptr <= {ab[1], ab[0]};
            if (cmd == 8'h06) mode <= int'(ab[2][6]);
          end else begin
            cmd <= pins.dq_out;
            na <= 0;
          end
        end else if (pins.ale) begin
          if (na < 3) ab[na] <= pins.dq_out;
          na <= na + 3'h1;
          ptr <= 0;
          if (cmd == 8'h90)
            mode <= pins.dq_out == 8'h20 ? 3 : 2;
          if (cmd == 8'hec) mode <= 4;
          if (cmd == 8'hec) busy <= BUSY_CYC;
        end
      end
      if (re_q && !pins.re_n) begin
        if (since < WHR - 1 || !ready) err <= 1;
        dq <= pick(mode, ptr);
        ptr <= ptr + 1;
      end
    end
  end
endmodule : nand_dev_model
`default_nettype wire

// [sim/tb_top.sv]
// testbench: host sequencer against the device model
// assumes the model answers on DQ_IN and READY
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin \
  n_mismatch++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  import nand_host_pkg::*;
  localparam logic [7:0] MFR = 8'h3c; // arbitrary value
  localparam logic [7:0] DEV = 8'h5a; // arbitrary value
  localparam logic [7:0] IDV [5] = '{MFR, DEV, 8'h90, 8'h95, 8'h04};
  localparam logic [7:0] ONF [4] = '{8'h4f, 8'h4e, 8'h46, 8'h49};
  logic CLOCK = 0;
  logic NRST = 0;
  logic REQ_VALID = 0;
  logic hold = 0;
  request_s REQ = '0;
  logic REQ_READY, RD_VALID, DONE, READY, err;
  logic [7:0] RD_DATA, DQ_IN;
  pins_s PINS;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 32'h082aa1a8;
  int md = 0;
  logic [7:0] got [$];
  always #2.5 CLOCK = ~CLOCK;
  nand_read_host nand_read_host_i (.CLOCK(CLOCK), .NRST(NRST),
    .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .DONE(DONE), .PINS(PINS),
    .DQ_IN(DQ_IN), .READY(READY));
  nand_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) nand_dev_model_i (
    .clock(CLOCK), .nrst(NRST), .pins(PINS), .hold_busy(hold),
    .dq_in(DQ_IN), .ready(READY), .err(err));
  always @(posedge CLOCK) if (RD_VALID === 1'b1) got.push_back(RD_DATA);
  // ----------------------------------------
  // expectations and transfers
  // ----------------------------------------
  function automatic logic [7:0] pbyte(logic [7:0] c);
    case (c)
      0, 1, 2, 3: return ONF[c[1:0]];
      133: return 8'hbc;
      134: return 8'h02;
      135: return 8'h10;
      136: return 8'h27;
      137: return 8'h19;
      164: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction : pbyte
  // integrity word over bytes 0-253, msb first, published onfi seed
  function automatic logic [15:0] pcrc();
    logic [15:0] k;
    k = 16'h4f4e;
    for (int i = 0; i < 254; i++) begin
      k = k ^ {pbyte(8'(i)), 8'h00};
      repeat (8) k = k[15] ? {k[14:0], 1'b0} ^ 16'h8005 : {k[14:0], 1'b0};
    end
    return k;
  endfunction : pcrc
  function automatic logic [7:0] expb(int m, logic [15:0] c);
    logic [15:0] k;
    k = pcrc();
    if (m < 2) return c[7:0] ^ (m == 1 ? 8'ha5 : 8'h00);
    if (m == 2) return IDV[c % 5];
    if (m == 3) return ONF[c % 4];
    if (c[7:0] == 8'hfe) return k[7:0];
    if (c[7:0] == 8'hff) return k[15:8];
    return pbyte(c[7:0]);
  endfunction : expb
  task automatic xfer(op_e op, logic [15:0] c, logic [23:0] r,
      logic [7:0] ia, logic [15:0] n, bit bz);
    int i;
    got.delete();
    hold = bz;
    REQ = '{op, c, r, ia, n};
    REQ_VALID = 1;
    // while the array is busy cle must stay low at the pins
    if (bz) repeat (20) begin
      @(negedge CLOCK);
      `CHK("cle_busy", 1'b0, PINS.cle)
    end
    if (bz) @(posedge CLOCK);
    if (bz) #1 hold = 0;
    i = 0;
    do begin
      @(negedge CLOCK);
      i++;
    end while (!(REQ_READY === 1'b1 && READY === 1'b1) && i < 1000);
    @(posedge CLOCK);
    #1 REQ_VALID = 0;
    i = 0;
    while (DONE !== 1'b1 && i < 20000) begin
      @(negedge CLOCK);
      i++;
    end
    `CHK("done", 1'b1, DONE)
    @(posedge CLOCK);
    #1;
    if (op == OP_PLANE) md = int'(r[6]);
    if (op == OP_IDENT) md = ia == 8'h20 ? 3 : 2;
    if (op == OP_PARAM) md = 4;
    if (op == OP_IDENT || op == OP_PARAM) c = 0;
    `CHK("count", n, 16'(got.size()))
    for (i = 0; i < got.size(); i++)
      `CHK("byte", expb(md, c + 16'(i)), got[i])
    `CHK("dev_err", 1'b0, err)
  endtask : xfer
  task print_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    int i;
    logic [15:0] c;
    logic [23:0] r;
    repeat (2) @(posedge CLOCK);
    #1 NRST = 1;
    @(posedge CLOCK);
    #1;
    `CHK("ready_rst", 1'b1, REQ_READY)
    `CHK("ce_rst", 1'b1, PINS.ce_n)
    xfer(OP_IDENT, 0, 0, 8'h00, 7, 0);
    xfer(OP_IDENT, 0, 0, 8'h20, 4, 0);
    xfer(OP_PARAM, 0, 0, 8'h00, 4, 0);
    xfer(OP_COLUMN, 16'd133, 0, 0, 6, 0);
    xfer(OP_COLUMN, 16'd420, 0, 0, 3, 0);
    xfer(OP_COLUMN, 16'd647, 0, 0, 2, 0);
    xfer(OP_COLUMN, 16'd766, 0, 0, 2, 0);
    xfer(OP_PLANE, 16'd2047, 24'h40, 0, 3, 1);
    for (i = 0; i < 6; i++) begin
      c = 16'({$random(seed)} % 2108);
      r = 24'($random(seed));
      r[23:17] = 0;
      r[6] = i[0];
      xfer(OP_PLANE, c, r, 0, 4, 0);
      // new column and its two bytes stay inside the 2112-byte page
      c = 16'((c ^ 16'h0155) % 2110);
      xfer(OP_COLUMN, c, 0, 0, 2, 0);
    end
    print_verdict;
  end
  // whole sequence needs well under a tenth of this
  initial begin
    #400000;
    n_mismatch++;
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
